// ---- cwe_bank_if.sv ----
`timescale 1ns/10ps
interface cwe_bank_if;
    logic        wr;
    logic [5:0]  idx;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  win_enable;
    logic [7:0]  io_control;
    logic [15:0] io_start [2];
    logic [15:0] io_end   [2];

    modport bank (
        input  wr,
        input  idx,
        input  wdata,
        output rdata,
        output win_enable,
        output io_control,
        output io_start,
        output io_end
    );
    modport core (
        output wr,
        output idx,
        output wdata,
        input  rdata,
        input  win_enable,
        input  io_control,
        input  io_start,
        input  io_end
    );
endinterface : cwe_bank_if

// ---- cwe_card_model.sv ----
`timescale 1ns/10ps
module cwe_card_model (
    input  wire logic       clk,
    input  wire logic [1:0] wide_mode,
    input  wire logic       claim,
    input  wire logic       busy,
    output logic      [1:0] wide_io,
    output logic      [5:0] busy_len
);
    // each socket's card raises its wide-io line as commanded
    assign wide_io = wide_mode;
    // strobe length as the card sees it, restarted at one by each claim
    always_ff @(posedge clk) begin
        if (claim) begin
            busy_len <= 6'h01;
        end else if (busy) begin
            busy_len <= busy_len + 6'h01;
        end
    end
endmodule : cwe_card_model

// ---- cwe_pkg.sv ----
package cwe_pkg;
    // register indices within one socket block
    localparam logic [5:0]  IDX_WINDOW_ENABLE = 6'h06;
    localparam logic [5:0]  IDX_IO_CONTROL    = 6'h07;
    localparam logic [5:0]  IDX_IO0_START_LOW = 6'h08;
    localparam logic [5:0]  IDX_IO1_START_LOW = 6'h0c;
    localparam logic [1:0]  OFS_START_LOW     = 2'h0;
    localparam logic [1:0]  OFS_START_HIGH    = 2'h1;
    localparam logic [1:0]  OFS_END_LOW       = 2'h2;
    localparam logic [1:0]  OFS_END_HIGH      = 2'h3;
    // socket B sits 40h higher, alias block at 800h
    localparam int          BIT_SOCKET        = 6;
    localparam int          BIT_ALIAS         = 11;
    localparam logic [3:0]  ALIAS_HIGH_NIBBLE = 4'h8;
    localparam logic [7:0]  RESET_VALUE       = 8'h00;
    // window enable fields
    localparam int          POS_IO1_ON        = 7;
    localparam int          POS_IO0_ON        = 6;
    localparam int          POS_RESERVED      = 5;
    localparam logic [7:0]  ENABLE_WRITE_MASK = 8'hdf;
    // io control fields, window n at 4*n
    localparam int          POS_EXTEND_16BIT  = 3;
    localparam int          POS_SHORTEN_8BIT  = 2;
    localparam int          POS_AUTO_SIZING   = 1;
    localparam int          POS_WIDTH_SELECT  = 0;
    localparam int          IO_CTRL_STRIDE    = 4;
    // cycle timing in isa clocks, converted to MCLK cycles
    localparam int          MCLK_PERIOD_NS    = 25;
    localparam int          ISA_CYCLE_NS      = 125;
    localparam int          ISA_CLKS          =
        (ISA_CYCLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int          ISA_LEN_8_STD     = 6;
    localparam int          ISA_LEN_8_ZERO    = 3;
    localparam int          ISA_LEN_16_STD    = 3;
    localparam int          ISA_LEN_16_WAIT   = 4;
    localparam int          ISA_LEN_MEM       = 3;
    localparam logic [5:0]  CLK_LEN_8_STD     = 6'(ISA_LEN_8_STD * ISA_CLKS);
    localparam logic [5:0]  CLK_LEN_8_ZERO    = 6'(ISA_LEN_8_ZERO * ISA_CLKS);
    localparam logic [5:0]  CLK_LEN_16_STD    = 6'(ISA_LEN_16_STD * ISA_CLKS);
    localparam logic [5:0]  CLK_LEN_16_WAIT   = 6'(ISA_LEN_16_WAIT * ISA_CLKS);
    localparam logic [5:0]  CLK_LEN_MEM       = 6'(ISA_LEN_MEM * ISA_CLKS);

    typedef enum logic {
        CWE_IDLE = 1'b0,
        CWE_RUN  = 1'b1
    } cwe_state_t;
endpackage : cwe_pkg

// ---- cwe_socket_bank.sv ----
`timescale 1ns/10ps
module cwe_socket_bank (
    input  wire logic  clk,
    input  wire logic  rst,
    cwe_bank_if.bank   bus
);
    logic [7:0]  win_enable;
    logic [7:0]  io_control;
    logic [7:0]  rd_addr [2];
    logic [7:0]  addr_byte [2][4];
    logic        hit_enable;
    logic        hit_control;

    assign hit_enable  = bus.wr && bus.idx == cwe_pkg::IDX_WINDOW_ENABLE;
    assign hit_control = bus.wr && bus.idx == cwe_pkg::IDX_IO_CONTROL;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_enable <= cwe_pkg::RESET_VALUE;
            io_control <= cwe_pkg::RESET_VALUE;
        end else begin
            if (hit_enable)
                // reserved bit never stores
                win_enable <= bus.wdata & cwe_pkg::ENABLE_WRITE_MASK;
            if (hit_control)
                io_control <= bus.wdata;
        end
    end

    genvar w, k;
    generate
        for (w = 0; w < 2; w++) begin : g_win
            localparam logic [5:0] BASE = (w == 0) ?
                cwe_pkg::IDX_IO0_START_LOW : cwe_pkg::IDX_IO1_START_LOW;
            for (k = 0; k < 4; k++) begin : g_byte
                logic hit;
                assign hit = bus.wr && bus.idx == BASE + 6'(k);
                always_ff @(posedge clk or posedge rst) begin
                    if (rst)
                        addr_byte[w][k] <= cwe_pkg::RESET_VALUE;
                    else if (hit)
                        addr_byte[w][k] <= bus.wdata;
                end
            end
            assign bus.io_start[w] =
                {addr_byte[w][cwe_pkg::OFS_START_HIGH],
                 addr_byte[w][cwe_pkg::OFS_START_LOW]};
            assign bus.io_end[w]   = {addr_byte[w][cwe_pkg::OFS_END_HIGH],
                                      addr_byte[w][cwe_pkg::OFS_END_LOW]};
            assign rd_addr[w] = (bus.idx[5:2] == BASE[5:2]) ?
                                addr_byte[w][bus.idx[1:0]] : 8'h00;
        end
    endgenerate

    assign bus.win_enable = win_enable;
    assign bus.io_control = io_control;
    assign bus.rdata =
        (bus.idx == cwe_pkg::IDX_WINDOW_ENABLE) ? win_enable :
        (bus.idx == cwe_pkg::IDX_IO_CONTROL)    ? io_control :
        (rd_addr[0] | rd_addr[1]);
endmodule : cwe_socket_bank

// ---- cwe_window_ctrl.sv ----
`timescale 1ns/10ps
// Contract
// - no cycle is claimed through a window whose enable bit is clear.
// - after reset every window is off; enable register reads 00h.
// - enable bit 7 turns on io window 1, bit 6 io window 0.
// - enable bits 4..0 turn on memory windows 4..0.
// - enable bit 5 reads zero; writes to it are dropped.
// - wait bit lengthens 16-bit io cycles by one isa wait state.
// - zero-wait bit shortens 8-bit io cycles to three isa cycles.
// - auto sizing takes width from the card wide-io indicator.
// - width select gives 8 bits at 0, 16 at 1, unless auto.
// - start low byte holds address bits 7..0, resets to zero.
// - socket B is 40h above A; all also reachable at 800h plus index.
// - start high byte holds address bits 15..8.
module cwe_window_ctrl (
    input  wire logic        MCLK,
    input  wire logic        RESET,
    input  wire logic [11:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    input  wire logic        HOST_IO_REQ,
    input  wire logic        HOST_MEM_REQ,
    input  wire logic        HOST_SOCKET,
    input  wire logic [15:0] HOST_ADDR,
    input  wire logic [4:0]  MEM_RANGE_HIT,
    input  wire logic [1:0]  CARD_WIDE_IO_INDICATOR,
    output logic             CYCLE_CLAIM,
    output logic             CYCLE_IO,
    output logic             CYCLE_WINDOW,
    output logic             CYCLE_WIDE,
    output logic             CYCLE_BUSY,
    output logic             CYCLE_DONE
);
    // address decode: alias block keeps the same low index
    logic        addr_ok;
    logic        sel_socket;
    logic [5:0]  sel_idx;
    assign addr_ok    = !REG_ADDR[cwe_pkg::BIT_ALIAS] ?
                        (REG_ADDR[10:7] == 4'h0) :
                        (REG_ADDR[11:8] == cwe_pkg::ALIAS_HIGH_NIBBLE &&
                         !REG_ADDR[7]);
    assign sel_socket = REG_ADDR[cwe_pkg::BIT_SOCKET];
    assign sel_idx    = REG_ADDR[5:0];

    logic [7:0]  sock_rdata   [2];
    logic [7:0]  sock_enable  [2];
    logic [7:0]  sock_control [2];
    logic [15:0] sock_start   [2][2];
    logic [15:0] sock_end     [2][2];

    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_sock
            cwe_bank_if bus ();
            assign bus.wr    = REG_WR && addr_ok && sel_socket == 1'(s);
            assign bus.idx   = sel_idx;
            assign bus.wdata = REG_WDATA;
            cwe_socket_bank u_bank (
                .clk (MCLK),
                .rst (RESET),
                .bus (bus)
            );
            assign sock_rdata[s]    = bus.rdata;
            assign sock_enable[s]   = bus.win_enable;
            assign sock_control[s]  = bus.io_control;
            assign sock_start[s][0] = bus.io_start[0];
            assign sock_start[s][1] = bus.io_start[1];
            assign sock_end[s][0]   = bus.io_end[0];
            assign sock_end[s][1]   = bus.io_end[1];
        end
    endgenerate

    logic [7:0] read_value;
    assign read_value = addr_ok ? sock_rdata[sel_socket] : 8'h00;

    // read data held until the next read
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
            REG_RDATA <= read_value;
    end

    // host cycle decode for the addressed socket
    logic [7:0] en;
    logic [7:0] ctl;
    logic [1:0] io_on;
    logic [1:0] in_range;
    logic [1:0] io_hit;
    logic       mem_hit;
    logic       win;
    logic       auto_sz;
    logic       wide;
    logic       extend;
    logic       shorten;
    logic [5:0] cycle_len;

    assign en  = sock_enable[HOST_SOCKET];
    assign ctl = sock_control[HOST_SOCKET];
    assign io_on = {en[cwe_pkg::POS_IO1_ON],
                    en[cwe_pkg::POS_IO0_ON]};

    genvar w;
    generate
        for (w = 0; w < 2; w++) begin : g_range
            assign in_range[w] =
                HOST_ADDR >= sock_start[HOST_SOCKET][w] &&
                HOST_ADDR <= sock_end[HOST_SOCKET][w];
            assign io_hit[w]   = io_on[w] && in_range[w];
        end
    endgenerate

    // memory ranges matched upstream, gated here by their enables
    assign mem_hit = |(en[4:0] & MEM_RANGE_HIT);

    // window 0 wins when both ranges overlap
    assign win     = !io_hit[0];
    assign auto_sz = ctl[cwe_pkg::IO_CTRL_STRIDE * win +
                         cwe_pkg::POS_AUTO_SIZING];
    assign wide    = auto_sz ? CARD_WIDE_IO_INDICATOR[HOST_SOCKET]
                   : ctl[cwe_pkg::IO_CTRL_STRIDE * win +
                         cwe_pkg::POS_WIDTH_SELECT];
    assign extend  = ctl[cwe_pkg::IO_CTRL_STRIDE * win +
                         cwe_pkg::POS_EXTEND_16BIT];
    assign shorten = ctl[cwe_pkg::IO_CTRL_STRIDE * win +
                         cwe_pkg::POS_SHORTEN_8BIT];
    assign cycle_len =
        wide ? (extend  ? cwe_pkg::CLK_LEN_16_WAIT
                        : cwe_pkg::CLK_LEN_16_STD)
             : (shorten ? cwe_pkg::CLK_LEN_8_ZERO
                        : cwe_pkg::CLK_LEN_8_STD);

    logic claim_io;
    logic claim_mem;
    assign claim_io  = HOST_IO_REQ && |io_hit;
    assign claim_mem = HOST_MEM_REQ && !HOST_IO_REQ && mem_hit;

    cwe_pkg::cwe_state_t state;
    cwe_pkg::cwe_state_t next_state;
    logic [5:0] count;
    logic [5:0] next_count;
    logic       start;
    logic       last;

    // requests during a running cycle are ignored, not queued
    assign start = state == cwe_pkg::CWE_IDLE && (claim_io || claim_mem);
    assign last  = state == cwe_pkg::CWE_RUN && count == 6'h01;

    always_comb begin
        next_state = state;
        next_count = count;
        unique case (state)
            cwe_pkg::CWE_IDLE: begin
                if (start) begin
                    next_state = cwe_pkg::CWE_RUN;
                    next_count = claim_io ? cycle_len : cwe_pkg::CLK_LEN_MEM;
                end
            end
            cwe_pkg::CWE_RUN: begin
                next_count = count - 6'h01;
                if (last)
                    next_state = cwe_pkg::CWE_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state <= cwe_pkg::CWE_IDLE;
            count <= 6'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // attributes latched at the start so register writes mid-cycle are safe
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            CYCLE_CLAIM  <= 1'b0;
            CYCLE_IO     <= 1'b0;
            CYCLE_WINDOW <= 1'b0;
            CYCLE_WIDE   <= 1'b0;
            CYCLE_DONE   <= 1'b0;
        end else begin
            CYCLE_CLAIM <= start;
            CYCLE_DONE  <= last;
            if (start) begin
                CYCLE_IO     <= claim_io;
                CYCLE_WINDOW <= claim_io & win;
                CYCLE_WIDE   <= claim_io & wide;
            end
        end
    end

    assign CYCLE_BUSY = state == cwe_pkg::CWE_RUN;
endmodule : cwe_window_ctrl

// ---- cwe_window_ctrl_sva.sv ----
`timescale 1ns/10ps
module cwe_window_ctrl_sva (
    input  wire logic        MCLK,
    input  wire logic        RESET,
    input  wire logic [11:0] REG_ADDR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_RDATA,
    input  wire logic        HOST_IO_REQ,
    input  wire logic        HOST_MEM_REQ,
    input  wire logic [4:0]  MEM_RANGE_HIT,
    input  wire logic        CYCLE_CLAIM,
    input  wire logic        CYCLE_IO,
    input  wire logic        CYCLE_WINDOW,
    input  wire logic        CYCLE_WIDE,
    input  wire logic        CYCLE_BUSY,
    input  wire logic        CYCLE_DONE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    chk_reset_quiet: assert property ($fell(RESET) |-> !CYCLE_CLAIM
        && !CYCLE_BUSY && !CYCLE_DONE && REG_RDATA == 8'h00)
        else $error("outputs not quiet after reset");
    chk_claim_cause: assert property (CYCLE_CLAIM |->
        $past((HOST_IO_REQ || HOST_MEM_REQ) && !CYCLE_BUSY))
        else $error("claim without an accepted request");
    chk_mem_claim: assert property (CYCLE_CLAIM && !CYCLE_IO |->
        $past(!HOST_IO_REQ && HOST_MEM_REQ && |MEM_RANGE_HIT))
        else $error("memory claim without a range hit");
    chk_mem_len: assert property (CYCLE_CLAIM && !CYCLE_IO |->
        CYCLE_BUSY ##15 CYCLE_DONE)
        else $error("memory cycle length wrong");
    chk_wide_len: assert property (
        CYCLE_CLAIM && CYCLE_IO && CYCLE_WIDE |->
        (##15 CYCLE_DONE) or (##20 CYCLE_DONE))
        else $error("wide io cycle length wrong");
    chk_narrow_len: assert property (
        CYCLE_CLAIM && CYCLE_IO && !CYCLE_WIDE |->
        (##15 CYCLE_DONE) or (##30 CYCLE_DONE))
        else $error("narrow io cycle length wrong");
    chk_done_end: assert property (CYCLE_DONE |->
        !CYCLE_BUSY && $past(CYCLE_BUSY))
        else $error("done not right after busy");
    chk_reserved_zero: assert property (
        $past(REG_RD && REG_ADDR[5:0] == 6'h06) |-> !REG_RDATA[5])
        else $error("reserved enable bit read as one");
    chk_unmapped_zero: assert property ($past(REG_RD
        && !REG_ADDR[11] && |REG_ADDR[10:7]) |-> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!$past(REG_RD) |->
        $stable(REG_RDATA))
        else $error("read data moved without a read");
    chk_kind_hold: assert property (!CYCLE_CLAIM |->
        $stable({CYCLE_IO, CYCLE_WINDOW, CYCLE_WIDE}))
        else $error("cycle kind moved without a claim");
endmodule : cwe_window_ctrl_sva

bind cwe_window_ctrl cwe_window_ctrl_sva i_sva (.MCLK, .RESET, .REG_ADDR,
    .REG_RD, .REG_RDATA, .HOST_IO_REQ, .HOST_MEM_REQ, .MEM_RANGE_HIT,
    .CYCLE_CLAIM, .CYCLE_IO, .CYCLE_WINDOW, .CYCLE_WIDE, .CYCLE_BUSY,
    .CYCLE_DONE);

// ---- cwe_window_ctrl_tb_top.sv ----
`timescale 1ns/10ps
module cwe_window_ctrl_tb_top;
    typedef struct packed {
        logic [11:0] wa;
        logic [7:0]  wd;
        logic [7:0]  rx;
        logic [1:0]  k;
        logic [15:0] ha;
        logic [1:0]  ind;
        logic        win;
        logic        wide;
        logic [5:0]  len;
    } cwe_row_t;
    // k: 0 none, 1 io socket A, 2 memory socket A, 3 io socket B
    cwe_row_t    rows [22] = '{
        '{12'h006,8'hff,8'hdf,2'h0,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h846,8'ha5,8'h85,2'h0,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h100,8'hff,8'h00,2'h0,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h880,8'hff,8'h00,2'h0,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h008,8'h10,8'h10,2'h0,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h00a,8'hff,8'hff,2'h0,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h00d,8'h03,8'h03,2'h0,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h00f,8'h03,8'h03,2'h0,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h006,8'h00,8'h00,2'h1,16'h0050,2'h0,1'b0,1'b0,6'h00},
        '{12'h006,8'hc1,8'hc1,2'h1,16'h0050,2'h0,1'b0,1'b0,6'h1e},
        '{12'h007,8'h04,8'h04,2'h1,16'h0010,2'h0,1'b0,1'b0,6'h0f},
        '{12'h007,8'h01,8'h01,2'h1,16'h00ff,2'h0,1'b0,1'b1,6'h0f},
        '{12'h007,8'h09,8'h09,2'h1,16'h0050,2'h0,1'b0,1'b1,6'h14},
        '{12'h007,8'h03,8'h03,2'h1,16'h0050,2'h0,1'b0,1'b0,6'h1e},
        '{12'h007,8'h02,8'h02,2'h1,16'h0050,2'h1,1'b0,1'b1,6'h0f},
        '{12'h007,8'h40,8'h40,2'h1,16'h0300,2'h2,1'b1,1'b0,6'h0f},
        '{12'h007,8'hb0,8'hb0,2'h1,16'h0300,2'h1,1'b1,1'b1,6'h14},
        '{12'h007,8'h00,8'h00,2'h1,16'h0100,2'h0,1'b0,1'b0,6'h00},
        '{12'h00e,8'h00,8'h00,2'h2,16'h0000,2'h0,1'b0,1'b0,6'h0f},
        '{12'h006,8'h80,8'h80,2'h2,16'h0000,2'h0,1'b0,1'b0,6'h00},
        '{12'h008,8'h10,8'h10,2'h1,16'h0050,2'h0,1'b0,1'b0,6'h00},
        '{12'h047,8'h00,8'h00,2'h3,16'h0000,2'h0,1'b1,1'b0,6'h1e}};
    logic [11:0] regs [4] = '{12'h006, 12'h007, 12'h008, 12'h00c};
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] ra = 12'h000;
    logic        rwr = 1'b0;
    logic        rrd = 1'b0;
    logic [7:0]  rwd = 8'h00;
    logic        hio = 1'b0;
    logic        hmem = 1'b0;
    logic        hsock = 1'b0;
    logic [15:0] haddr = 16'h0000;
    logic [4:0]  mhit = 5'h00;
    logic [1:0]  wmode = 2'h0;
    logic [1:0]  wio;
    logic [7:0]  rdat;
    logic [7:0]  d;
    logic [5:0]  blen;
    logic        claim, cyc_io, cyc_win, cyc_wide, busy, done, c;
    cwe_row_t    r;
    int          fails = 0;
    int          n_checks = 0;
    int          cycles = 0;

    cwe_window_ctrl i_dut (.MCLK(mclk), .RESET(rst), .REG_ADDR(ra),
        .REG_WR(rwr), .REG_RD(rrd), .REG_WDATA(rwd), .REG_RDATA(rdat),
        .HOST_IO_REQ(hio), .HOST_MEM_REQ(hmem), .HOST_SOCKET(hsock),
        .HOST_ADDR(haddr), .MEM_RANGE_HIT(mhit),
        .CARD_WIDE_IO_INDICATOR(wio), .CYCLE_CLAIM(claim),
        .CYCLE_IO(cyc_io), .CYCLE_WINDOW(cyc_win), .CYCLE_WIDE(cyc_wide),
        .CYCLE_BUSY(busy), .CYCLE_DONE(done));
    cwe_card_model i_card (.clk(mclk), .wide_mode(wmode), .claim(claim),
        .busy(busy), .wide_io(wio), .busy_len(blen));

    always #12.5 mclk = ~mclk;

    task chk_val(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk_val
    task chk_bit(input string what, input logic e, input logic g);
        chk_val(what, {7'h00, e}, {7'h00, g});
    endtask : chk_bit
    task wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge mclk);
        ra <= a;
        rwd <= v;
        rwr <= 1'b1;
        @(posedge mclk);
        rwr <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge mclk);
        ra <= a;
        rrd <= 1'b1;
        @(posedge mclk);
        rrd <= 1'b0;
        #1 v = rdat;
    endtask : rd
    // one-cycle request pulse; claim is looked at in the cycle after
    task host(input logic [1:0] k, input logic [15:0] a,
              input logic [1:0] ind, output logic cl);
        @(posedge mclk);
        hio <= k[0];
        hmem <= (k == 2'h2);
        hsock <= (k == 2'h3);
        haddr <= a;
        mhit <= {4'h0, k == 2'h2};
        wmode <= ind;
        @(posedge mclk);
        hio <= 1'b0;
        hmem <= 1'b0;
        #1 cl = claim;
    endtask : host
    task final_report;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // whole run is near 340 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            wr(r.wa, r.wd);
            rd(r.wa ^ 12'h800, d);
            chk_val("readback", r.rx, d);
            if (r.k != 2'h0) begin
                host(r.k, r.ha, r.ind, c);
                chk_bit("claim", r.len != 6'h00, c);
                if (c === 1'b1) begin
                    chk_bit("io cycle", r.k != 2'h2, cyc_io);
                    if (r.k != 2'h2) begin
                        chk_bit("window", r.win, cyc_win);
                        chk_bit("width", r.wide, cyc_wide);
                    end
                    for (int n = 0; n < 40 && done !== 1'b1; n++) begin
                        @(posedge mclk);
                        #1;
                    end
                    chk_bit("done", 1'b1, done);
                    chk_val("length", 8'(r.len), 8'(blen));
                end
            end
            $display("row %0d done", i);
        end
        wr(12'h006, 8'hc1);
        host(2'h1, 16'h0050, 2'h0, c);
        chk_bit("first claim", 1'b1, c);
        host(2'h1, 16'h0050, 2'h0, c);
        chk_bit("refused while busy", 1'b0, c);
        $display("busy refusal done");
        // reset lands in mid cycle on purpose
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        #1 chk_bit("busy in reset", 1'b0, busy);
        @(posedge mclk);
        rst <= 1'b0;
        foreach (regs[j]) begin
            rd(regs[j], d);
            chk_val("reset value", 8'h00, d);
        end
        $display("reset test done");
        final_report();
    end
endmodule : cwe_window_ctrl_tb_top
